// >>> bench/rdc_regs_assertions.sv
// Port-level checks for the receive delay control registers
`default_nettype none
module rdc_regs_checker
  import rdc_pkg::*;
#(
  parameter int INIT_WORDS = 1048576
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [9:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  input wire logic [7:0] up_rdata,
  input wire logic test_mode_en,
  input wire logic xfer_rdata_valid,
  input wire logic sram_direct_addr,
  input wire logic sram_core_block,
  input wire logic sram_dout_oe,
  input wire logic sram_ce_n,
  input wire logic sram_oe_n,
  input wire logic sram_we_n,
  input wire logic cell_tick,
  input wire logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] guardband,
  input wire logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] group_delay
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Idle bus only: a start during a fill gap is refused
  logic ctl_wr;
  assign ctl_wr = up_wr && up_addr == RDC_OFS_XFER_CTRL && sram_ce_n;

  property step_by_guardband;
    cell_tick |=> group_delay[0] == $past(group_delay[0]) || group_delay[0] == 14'h0000
      || group_delay[0] == 14'h3FFF
      || group_delay[0] == $past(group_delay[0]) + $past(guardband[0])
      || group_delay[0] == $past(group_delay[0]) - $past(guardband[0]);
  endproperty

  a_read_cycle: assert property (ctl_wr && up_wdata[5] && up_wdata[1:0] == 2'b01
    |-> ##2 (!sram_ce_n && !sram_oe_n)[*2] ##1 sram_ce_n) else $error("read strobe wrong");
  a_write_cycle: assert property (ctl_wr && !up_wdata[5] && up_wdata[1:0] == 2'b01
    |-> ##2 (!sram_ce_n && !sram_we_n)[*2] ##1 sram_we_n) else $error("write strobe wrong");
  a_read_valid: assert property (ctl_wr && up_wdata[5] && up_wdata[1:0] == 2'b01
    |-> ##5 xfer_rdata_valid) else $error("read byte not handed back");
  a_no_action: assert property (ctl_wr && up_wdata[1] |=> sram_ce_n[*4])
    else $error("RAM touched with no action");
  a_oe_exclusive: assert property (!sram_oe_n |-> sram_we_n && !sram_dout_oe)
    else $error("read and drive overlap");
  a_test_gate: assert property (!test_mode_en |=> !sram_direct_addr && !sram_core_block)
    else $error("test flag without test mode");
  a_high_zero: assert property (up_rd && up_addr == RDC_OFS_DLY_HIGH
    |=> up_rdata[7:6] == 2'b00) else $error("high readout bits 7:6 set");
  a_read_hold: assert property (!up_rd |=> $stable(up_rdata))
    else $error("read data moved without read");
  a_tick_only: assert property (!cell_tick |=> $stable(group_delay))
    else $error("delay moved without tick");
  a_step_size: assert property (step_by_guardband)
    else $error("delay step not guardband");

  c_read: cover property (ctl_wr && up_wdata[5:0] == 6'h21);
  c_write: cover property (ctl_wr && up_wdata[5:0] == 6'h01);
  c_step: cover property (cell_tick ##1 $changed(group_delay));
endmodule : rdc_regs_checker

bind rdc_regs rdc_regs_checker #(.INIT_WORDS(INIT_WORDS)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .up_addr(up_addr), .up_wdata(up_wdata),
  .up_wr(up_wr), .up_rd(up_rd), .up_rdata(up_rdata), .test_mode_en(test_mode_en),
  .xfer_rdata_valid(xfer_rdata_valid),
  .sram_direct_addr(sram_direct_addr), .sram_core_block(sram_core_block),
  .sram_dout_oe(sram_dout_oe), .sram_ce_n(sram_ce_n), .sram_oe_n(sram_oe_n),
  .sram_we_n(sram_we_n), .cell_tick(cell_tick), .guardband(guardband),
  .group_delay(group_delay));
`default_nettype wire

// >>> bench/rdc_sram_model.sv
// Behavioural external receive RAM
`default_nettype none
module rdc_sram_model
  import rdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [RDC_RAM_AW-1:0] sram_addr,
  input wire logic [7:0] sram_dout,
  input wire logic sram_dout_oe,
  output logic [7:0] sram_din,
  input wire logic sram_ce_n,
  input wire logic sram_oe_n,
  input wire logic sram_we_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Only 16 words: higher addresses alias
  logic [7:0] mem [16];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'hEE;
    end
  end
  // Released bus shows the inverse, never a stale copy
  assign sram_din = (!sram_ce_n && !sram_oe_n) ? mem[sram_addr[3:0]] : ~last;
  always @(posedge core_clk) begin
    if (!sram_ce_n && !sram_we_n && sram_dout_oe) begin
      mem[sram_addr[3:0]] <= sram_dout;
    end
    if (!sram_ce_n && !sram_oe_n) begin
      last <= mem[sram_addr[3:0]];
    end
  end
endmodule : rdc_sram_model
`default_nettype wire

// >>> bench/tb_rdc_regs.sv
// Self-checking bench for the receive delay control registers
`default_nettype none
module tb_rdc_regs
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] up_addr = 10'h000;
  logic [7:0] up_wdata = 8'h00;
  logic up_wr = 1'b0;
  logic up_rd = 1'b0;
  logic test_mode_en = 1'b0;
  logic cell_tick = 1'b0;
  logic [19:0] xfer_addr = 20'h00000;
  logic [7:0] xfer_wdata = 8'h00;
  logic [7:0] up_rdata, xfer_rdata, sram_dout, sram_din, v;
  logic [19:0] sram_addr;
  logic sram_dout_oe, sram_ce_n, sram_oe_n, sram_we_n, sram_direct_addr, sram_core_block;
  logic [3:0][13:0] guardband, group_delay, grp_cur_max, grp_cur_min;
  logic [3:0][2:0] grp_cur_max_link, grp_cur_min_link;
  logic [7:0][1:0] link_group;
  logic [7:0][13:0] link_delay, link_rd_ptr, link_wr_ptr;
  logic [9:0] ofs [7] = '{10'h280, 10'h281, 10'h284, 10'h285, 10'h286, 10'h29D, 10'h282};
  logic [7:0] rv [7] = '{8'h80, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  rdc_regs #(.INIT_WORDS(16)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .up_addr(up_addr), .up_wdata(up_wdata),
    .up_wr(up_wr), .up_rd(up_rd), .up_rdata(up_rdata), .test_mode_en(test_mode_en),
    .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_rdata(xfer_rdata),
    .xfer_rdata_valid(), .sram_direct_addr(sram_direct_addr),
    .sram_core_block(sram_core_block), .sram_addr(sram_addr), .sram_dout(sram_dout),
    .sram_dout_oe(sram_dout_oe), .sram_din(sram_din), .sram_ce_n(sram_ce_n),
    .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n), .cell_tick(cell_tick),
    .guardband(guardband), .group_delay(group_delay), .link_group(link_group),
    .link_delay(link_delay), .link_rd_ptr(link_rd_ptr), .link_wr_ptr(link_wr_ptr),
    .grp_cur_max(grp_cur_max), .grp_cur_max_link(grp_cur_max_link),
    .grp_cur_min(grp_cur_min), .grp_cur_min_link(grp_cur_min_link));

  rdc_sram_model mdl (
    .core_clk(core_clk), .sram_addr(sram_addr), .sram_dout(sram_dout),
    .sram_dout_oe(sram_dout_oe), .sram_din(sram_din), .sram_ce_n(sram_ce_n),
    .sram_oe_n(sram_oe_n), .sram_we_n(sram_we_n));

  always #12.5 core_clk = ~core_clk;

  task automatic results;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk14(input logic [13:0] g, input logic [13:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk14

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk);
    up_addr = a;
    up_wdata = d;
    up_wr = 1'b1;
    @(negedge core_clk);
    up_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge core_clk);
    up_addr = a;
    up_rd = 1'b1;
    @(negedge core_clk);
    up_rd = 1'b0;
    d = up_rdata;
  endtask : rd

  task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(d, e);
  endtask : rdchk

  task automatic wait_done;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 100 && s[7] !== 1'b1; i++) begin
      rd(RDC_OFS_XFER_CTRL, s);
    end
    chk8(s & 8'h80, 8'h80);
  endtask : wait_done

  task automatic tick;
    @(negedge core_clk);
    cell_tick = 1'b1;
    @(negedge core_clk);
    cell_tick = 1'b0;
    @(negedge core_clk);
  endtask : tick

  task automatic gd(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c,
                    input logic [13:0] d);
    chk14(group_delay[0], a);
    chk14(group_delay[1], b);
    chk14(group_delay[2], c);
    chk14(group_delay[3], d);
  endtask : gd

  task automatic sel(input logic [7:0] s, input logic [13:0] e, input logic [7:0] l);
    logic [7:0] h;
    logic [7:0] lo;
    logic [7:0] k;
    wr(RDC_OFS_SELECT, s);
    rd(RDC_OFS_DLY_HIGH, h);
    rd(RDC_OFS_DLY_LOW, lo);
    rd(RDC_OFS_LINK_NUM, k);
    chk14({h[5:0], lo}, e);
    chk8(h & 8'hC0, 8'h00);
    chk8(k & 8'h07, l);
  endtask : sel

  initial begin
    for (int i = 0; i < 8; i++) begin
      link_group[i] = 2'(i);
      link_delay[i] = 14'h0120 + 14'(i);
      link_rd_ptr[i] = 14'h0A00 + 14'(i);
      link_wr_ptr[i] = 14'h1B00 + 14'(i);
    end
    for (int g = 0; g < 4; g++) begin
      guardband[g] = 14'h0104 * 14'(g + 1);
      grp_cur_max[g] = 14'h0300 + 14'(g);
      grp_cur_min[g] = 14'h0050 + 14'(g);
      grp_cur_max_link[g] = 3'(g + 4);
      grp_cur_min_link[g] = 3'(g);
    end
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    // Toggle bit 6 is undefined after reset, so it is masked
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], v);
      chk8(v & (i == 0 ? 8'hBF : 8'hFF), rv[i]);
    end
    wr(RDC_OFS_LINK_NUM, 8'h10);
    xfer_addr = 20'h00005;
    xfer_wdata = 8'hA5;
    wr(RDC_OFS_XFER_CTRL, 8'h01);
    rd(RDC_OFS_XFER_CTRL, v);
    chk8(v & 8'h80, 8'h00);
    wait_done();
    chk8(mdl.mem[5], 8'hA5);
    xfer_wdata = 8'h00;
    wr(RDC_OFS_XFER_CTRL, 8'h21);
    wait_done();
    chk8(xfer_rdata, 8'hA5);
    wr(RDC_OFS_XFER_CTRL, 8'h00);
    wait_done();
    for (int i = 0; i < 16; i++) begin
      chk8(mdl.mem[i], 8'h00);
    end
    test_mode_en = 1'b1;
    wr(RDC_OFS_XFER_CTRL, 8'h0E);
    wait_done();
    chk8({6'h00, sram_direct_addr, sram_core_block}, 8'h03);
    test_mode_en = 1'b0;
    repeat (2) @(negedge core_clk);
    chk8({6'h00, sram_direct_addr, sram_core_block}, 8'h00);
    wr(RDC_OFS_ADJUST, 8'h95);
    rdchk(RDC_OFS_ADJUST, 8'h95);
    tick();
    gd(14'h0104, 14'h0208, 14'h030C, 14'h0000);
    rdchk(RDC_OFS_ADJUST, 8'h00);
    wr(RDC_OFS_ADJUST, 8'h00);
    tick();
    gd(14'h0104, 14'h0208, 14'h030C, 14'h0000);
    wr(RDC_OFS_ADJUST, 8'h26);
    tick();
    gd(14'h0000, 14'h0410, 14'h0000, 14'h0000);
    sel(8'h03, link_delay[3] + guardband[link_group[3]], 8'h03);
    sel(8'h09, grp_cur_min[1] + guardband[1], 8'h01);
    sel(8'h12, grp_cur_max[2] + guardband[2], 8'h06);
    sel(8'h18, grp_cur_max[0] + guardband[0], 8'h00);
    sel(8'h45, link_rd_ptr[5], 8'h05);
    sel(8'h86, link_wr_ptr[6], 8'h06);
    link_wr_ptr[6] = 14'h0000;
    rdchk(RDC_OFS_DLY_LOW, 8'h06);
    grp_cur_max[0] = 14'h0100;
    sel(8'h18, 14'h0404, 8'h00);
    wr(RDC_OFS_SELECT, 8'h38);
    sel(8'h18, 14'h0204, 8'h00);
    results();
  end
endmodule : tb_rdc_regs
`default_nettype wire

// >>> hw/rdc_pkg.sv
// Constants, offsets and helpers of the receive delay control registers
`default_nettype none
package rdc_pkg;
  localparam int RDC_DLY_W = 14;
  localparam int RDC_GROUPS = 4;
  localparam int RDC_LINKS = 8;
  localparam int RDC_RAM_AW = 20;

  // Register offsets on the microprocessor port
  localparam logic [9:0] RDC_OFS_XFER_CTRL = 10'h280;
  localparam logic [9:0] RDC_OFS_ADJUST = 10'h281;
  localparam logic [9:0] RDC_OFS_DLY_HIGH = 10'h284;
  localparam logic [9:0] RDC_OFS_DLY_LOW = 10'h285;
  localparam logic [9:0] RDC_OFS_LINK_NUM = 10'h286;
  localparam logic [9:0] RDC_OFS_SELECT = 10'h29D;

  // Values after reset
  localparam logic [7:0] RDC_RST_XFER_CTRL = 8'h80;
  localparam logic [7:0] RDC_RST_ADJUST = 8'h00;
  localparam logic [7:0] RDC_RST_DLY_HIGH = 8'h00;
  localparam logic [7:0] RDC_RST_DLY_LOW = 8'h04;
  localparam logic [7:0] RDC_RST_LINK_NUM = 8'h00;
  localparam logic [7:0] RDC_RST_SELECT = 8'h00;

  // Field positions
  localparam int RDC_XC_DIR_BIT = 5;
  localparam int RDC_XC_DIRECT_BIT = 3;
  localparam int RDC_XC_BLOCK_BIT = 2;
  localparam int RDC_XC_NOACT_BIT = 1;
  localparam int RDC_SEL_CLR_BIT = 5;

  // Select field codes
  localparam logic [1:0] RDC_SRC_DELAY = 2'h0;
  localparam logic [1:0] RDC_SRC_RD_PTR = 2'h1;
  localparam logic [1:0] RDC_SRC_WR_PTR = 2'h2;
  localparam logic [1:0] RDC_STAT_LINK = 2'h0;
  localparam logic [1:0] RDC_STAT_GMIN = 2'h1;
  localparam logic [1:0] RDC_STAT_GMAX = 2'h2;
  localparam logic [1:0] RDC_STAT_MOT = 2'h3;

  // Cycles per external RAM strobe
  localparam int RDC_ACCESS_CYC = 2;

  function automatic logic [RDC_DLY_W-1:0] rdc_sat_add(input logic [RDC_DLY_W-1:0] a,
                                                       input logic [RDC_DLY_W-1:0] b);
    logic [RDC_DLY_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[RDC_DLY_W] ? {RDC_DLY_W{1'b1}} : s[RDC_DLY_W-1:0];
  endfunction : rdc_sat_add

  function automatic logic [RDC_DLY_W-1:0] rdc_sat_sub(input logic [RDC_DLY_W-1:0] a,
                                                       input logic [RDC_DLY_W-1:0] b);
    return (a > b) ? a - b : '0;
  endfunction : rdc_sat_sub
endpackage : rdc_pkg
`default_nettype wire

// >>> hw/rdc_regs.sv
// Receive delay control register bank with external RAM transfer control
`default_nettype none
module rdc_regs
  import rdc_pkg::*;
#(
  parameter int INIT_WORDS = 1048576
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [9:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  output logic [7:0] up_rdata,
  input wire logic test_mode_en,
  input wire logic [RDC_RAM_AW-1:0] xfer_addr,
  input wire logic [7:0] xfer_wdata,
  output logic [7:0] xfer_rdata,
  output logic xfer_rdata_valid,
  output logic sram_direct_addr,
  output logic sram_core_block,
  output logic [RDC_RAM_AW-1:0] sram_addr,
  output logic [7:0] sram_dout,
  output logic sram_dout_oe,
  input wire logic [7:0] sram_din,
  output logic sram_ce_n,
  output logic sram_oe_n,
  output logic sram_we_n,
  input wire logic cell_tick,
  input wire logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] guardband,
  output logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] group_delay,
  input wire logic [RDC_LINKS-1:0][1:0] link_group,
  input wire logic [RDC_LINKS-1:0][RDC_DLY_W-1:0] link_delay,
  input wire logic [RDC_LINKS-1:0][RDC_DLY_W-1:0] link_rd_ptr,
  input wire logic [RDC_LINKS-1:0][RDC_DLY_W-1:0] link_wr_ptr,
  input wire logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] grp_cur_max,
  input wire logic [RDC_GROUPS-1:0][2:0] grp_cur_max_link,
  input wire logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] grp_cur_min,
  input wire logic [RDC_GROUPS-1:0][2:0] grp_cur_min_link
);
  // Whole register state in one word, registered in one place
  typedef struct packed {
    logic xc_done;
    logic xc_toggle;
    logic [5:0] xc_ctrl;
    logic xc_busy;
    logic [7:0] adjust;
    logic [7:0] select;
    logic update;
    logic [5:0] dly_high;
    logic [7:0] dly_low;
    logic [4:0] link_cfg;
    logic [2:0] link_num;
    logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] max_time;
    logic [RDC_GROUPS-1:0][RDC_DLY_W-1:0] gdelay;
    logic start;
    logic local_done;
    logic [7:0] rdata;
    logic [7:0] xrdata;
    logic xvalid;
    logic direct;
    logic block;
  } rdc_regs_t;

  rdc_regs_t q, d;
  rdc_xfer_if xf ();

  // Readout selection decoded from the stored select word
  logic [1:0] src;
  logic [1:0] stat;
  logic [2:0] lnk;
  logic [1:0] grp;
  logic [RDC_DLY_W-1:0] value;
  logic [2:0] vlink;
  // Write strobes, one per writable register
  logic wr_xc;
  logic wr_sel;
  logic wr_adj;
  logic wr_high;
  logic wr_low;
  logic wr_link;

  // One decoder for every strobe keeps the offsets in a single place
  function automatic logic hit(input logic stb, input logic [9:0] a, input logic [9:0] ofs);
    return stb && (a == ofs);
  endfunction : hit

  // Port taken as synchronous to the core clock, so no synchronisers
  assign wr_xc = hit(up_wr, up_addr, RDC_OFS_XFER_CTRL);
  assign wr_sel = hit(up_wr, up_addr, RDC_OFS_SELECT);
  assign wr_adj = hit(up_wr, up_addr, RDC_OFS_ADJUST);
  assign wr_high = hit(up_wr, up_addr, RDC_OFS_DLY_HIGH);
  assign wr_low = hit(up_wr, up_addr, RDC_OFS_DLY_LOW);
  assign wr_link = hit(up_wr, up_addr, RDC_OFS_LINK_NUM);

  // Readout source; captured one cycle after the select write
  always_comb begin
    src = q.select[7:6];
    stat = q.select[4:3];
    lnk = q.select[2:0];
    grp = q.select[1:0];
    value = '0;
    vlink = lnk;
    // Pointers are raw positions and carry no guardband
    if (src == RDC_SRC_RD_PTR) begin
      value = link_rd_ptr[lnk];
    end else if (src == RDC_SRC_WR_PTR) begin
      value = link_wr_ptr[lnk];
    end else begin
      // Code 11 of the source field is undefined and treated as delay
      unique case (stat)
        RDC_STAT_LINK: begin
          value = rdc_sat_add(link_delay[lnk], guardband[link_group[lnk]]);
        end
        RDC_STAT_GMIN: begin
          value = rdc_sat_add(grp_cur_min[grp], guardband[grp]);
          vlink = grp_cur_min_link[grp];
        end
        RDC_STAT_GMAX: begin
          value = rdc_sat_add(grp_cur_max[grp], guardband[grp]);
          vlink = grp_cur_max_link[grp];
        end
        RDC_STAT_MOT: begin
          value = rdc_sat_add(q.max_time[grp], guardband[grp]);
          vlink = '0;
        end
      endcase
    end
  end

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.local_done = 1'b0;
    d.xvalid = 1'b0;
    d.update = 1'b0;

    // Transfer control
    if (wr_xc) begin
      d.xc_ctrl = up_wdata[5:0];
      d.xc_done = 1'b0;
      if (up_wdata[RDC_XC_NOACT_BIT]) begin
        // While busy the running transfer brings the flag back
        d.local_done = !q.xc_busy;
      end else if (!q.xc_busy) begin
        d.start = 1'b1;
        d.xc_busy = 1'b1;
      end
    end
    // Completion after the clear, so a finish in the same cycle wins
    if (xf.done || q.local_done) begin
      d.xc_done = 1'b1;
      d.xc_toggle = ~q.xc_toggle;
    end
    if (xf.done) begin
      d.xc_busy = 1'b0;
    end
    // Only a single read hands a byte back; a single write or a fill returns none
    if (xf.done && q.xc_ctrl[RDC_XC_DIR_BIT] && q.xc_ctrl[0]) begin
      d.xrdata = xf.rdata;
      d.xvalid = 1'b1;
    end
    d.direct = test_mode_en && q.xc_ctrl[RDC_XC_DIRECT_BIT];
    d.block = test_mode_en && q.xc_ctrl[RDC_XC_BLOCK_BIT];

    // Delay steps applied on the cell boundary
    // Increment wins if both bits of one group are set
    if (cell_tick) begin
      for (int g = 0; g < RDC_GROUPS; g++) begin
        if (q.adjust[2*g]) begin
          d.gdelay[g] = rdc_sat_add(q.gdelay[g], guardband[g]);
          d.adjust[2*g] = 1'b0;
        end else if (q.adjust[2*g+1]) begin
          d.gdelay[g] = rdc_sat_sub(q.gdelay[g], guardband[g]);
          d.adjust[2*g+1] = 1'b0;
        end
      end
    end
    // A new request arriving with the self-clear is kept
    if (wr_adj) begin
      d.adjust = d.adjust | up_wdata;
    end

    // Maximum over time; clear first so a new peak is still seen
    if (wr_sel && up_wdata[RDC_SEL_CLR_BIT]) begin
      d.max_time[up_wdata[1:0]] = '0;
    end
    // Tracks the live maximum every cycle, not only on ticks
    for (int g = 0; g < RDC_GROUPS; g++) begin
      if (grp_cur_max[g] > d.max_time[g]) begin
        d.max_time[g] = grp_cur_max[g];
      end
    end

    // Select register and readout capture
    if (wr_sel) begin
      d.select = up_wdata;
      d.update = 1'b1;
    end
    if (q.update) begin
      d.dly_high = value[RDC_DLY_W-1:8];
      d.dly_low = value[7:0];
      d.link_num = vlink;
    end
    // Software may overwrite readouts; a write in the capture cycle wins
    if (wr_high) begin
      d.dly_high = up_wdata[5:0];
    end
    if (wr_low) begin
      d.dly_low = up_wdata;
    end
    if (wr_link) begin
      d.link_cfg = up_wdata[7:3];
    end

    // Read data, one cycle after the strobe; unmapped reads as zero
    if (up_rd) begin
      unique case (up_addr)
        RDC_OFS_XFER_CTRL: d.rdata = {q.xc_done, q.xc_toggle, q.xc_ctrl};
        RDC_OFS_ADJUST: d.rdata = q.adjust;
        RDC_OFS_DLY_HIGH: d.rdata = {2'h0, q.dly_high};
        RDC_OFS_DLY_LOW: d.rdata = q.dly_low;
        RDC_OFS_LINK_NUM: d.rdata = {q.link_cfg, q.link_num};
        RDC_OFS_SELECT: d.rdata = q.select;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // Toggle bit starts at 0, though software treats it as undefined
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.xc_done <= RDC_RST_XFER_CTRL[7];
      q.xc_ctrl <= RDC_RST_XFER_CTRL[5:0];
      q.adjust <= RDC_RST_ADJUST;
      q.select <= RDC_RST_SELECT;
      q.dly_high <= RDC_RST_DLY_HIGH[5:0];
      q.dly_low <= RDC_RST_DLY_LOW;
      q.link_cfg <= RDC_RST_LINK_NUM[7:3];
      q.link_num <= RDC_RST_LINK_NUM[2:0];
    end else begin
      q <= d;
    end
  end

  // Address and data pass live; the engine latches them when the transfer starts
  assign xf.start = q.start;
  assign xf.init = (q.xc_ctrl[0] == 1'b0);
  assign xf.dir = q.xc_ctrl[RDC_XC_DIR_BIT];
  assign xf.addr = xfer_addr;
  assign xf.wdata = xfer_wdata;

  // Engine owns the RAM address, data and strobe pins; this bank only starts it
  rdc_xfer #(
    .INIT_WORDS(INIT_WORDS)
  ) u_xfer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .xf(xf.eng),
    .sram_addr(sram_addr),
    .sram_dout(sram_dout),
    .sram_dout_oe(sram_dout_oe),
    .sram_din(sram_din),
    .sram_ce_n(sram_ce_n),
    .sram_oe_n(sram_oe_n),
    .sram_we_n(sram_we_n)
  );

  // Every output comes straight from a register
  assign up_rdata = q.rdata;
  assign xfer_rdata = q.xrdata;
  assign xfer_rdata_valid = q.xvalid;
  assign sram_direct_addr = q.direct;
  assign sram_core_block = q.block;
  assign group_delay = q.gdelay;
endmodule : rdc_regs
`default_nettype wire

// >>> hw/rdc_xfer.sv
// External receive RAM transfer engine: single read, single write, fill
`default_nettype none
module rdc_xfer
  import rdc_pkg::*;
#(
  parameter int INIT_WORDS = 1048576
) (
  input wire logic core_clk,
  input wire logic rst_n,
  rdc_xfer_if.eng xf,
  output logic [RDC_RAM_AW-1:0] sram_addr,
  output logic [7:0] sram_dout,
  output logic sram_dout_oe,
  input wire logic [7:0] sram_din,
  output logic sram_ce_n,
  output logic sram_oe_n,
  output logic sram_we_n
);
  typedef enum logic [1:0] {X_IDLE, X_READ, X_WRITE, X_FILL} rdc_xst_t;
  typedef struct packed {
    rdc_xst_t st;
    logic [7:0] cnt;
    logic [RDC_RAM_AW-1:0] addr;
    logic [7:0] dout;
    logic oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic done;
    logic [7:0] rdata;
  } rdc_xfer_t;

  localparam logic [7:0] LAST = 8'(RDC_ACCESS_CYC - 1);
  localparam logic [7:0] REL = 8'(RDC_ACCESS_CYC);
  localparam logic [RDC_RAM_AW-1:0] TOP = RDC_RAM_AW'(INIT_WORDS - 1);

  rdc_xfer_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      X_IDLE: begin
        d.cnt = '0;
        if (xf.start) begin
          d.ce_n = 1'b0;
          if (xf.init) begin
            d.st = X_FILL;
            d.addr = '0;
            d.dout = '0;
            d.oe = 1'b1;
            d.we_n = 1'b0;
          end else if (xf.dir) begin
            d.st = X_READ;
            d.addr = xf.addr;
            d.oe_n = 1'b0;
          end else begin
            d.st = X_WRITE;
            d.addr = xf.addr;
            d.dout = xf.wdata;
            d.oe = 1'b1;
            d.we_n = 1'b0;
          end
        end
      end
      X_READ: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == LAST) begin
          d.rdata = sram_din;
          d.oe_n = 1'b1;
          d.ce_n = 1'b1;
          d.done = 1'b1;
          d.st = X_IDLE;
        end
      end
      X_WRITE, X_FILL: begin
        d.cnt = q.cnt + 8'h01;
        // Write strobe rises one cycle before address or data move
        if (q.cnt == LAST) begin
          d.we_n = 1'b1;
        end else if (q.cnt == REL) begin
          if (q.st == X_FILL && q.addr != TOP) begin
            d.addr = q.addr + 1'b1;
            d.cnt = '0;
            d.we_n = 1'b0;
          end else begin
            d.oe = 1'b0;
            d.ce_n = 1'b1;
            d.done = 1'b1;
            d.st = X_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= X_IDLE;
      q.ce_n <= 1'b1;
      q.oe_n <= 1'b1;
      q.we_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign xf.done = q.done;
  assign xf.rdata = q.rdata;
  assign sram_addr = q.addr;
  assign sram_dout = q.dout;
  assign sram_dout_oe = q.oe;
  assign sram_ce_n = q.ce_n;
  assign sram_oe_n = q.oe_n;
  assign sram_we_n = q.we_n;
endmodule : rdc_xfer
`default_nettype wire

// >>> hw/rdc_xfer_if.sv
// Carrier between the register bank and the external RAM transfer engine
`default_nettype none
interface rdc_xfer_if;
  logic start;
  logic init;
  logic dir;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctrl (output start, output init, output dir, output addr, output wdata,
                input done, input rdata);
  modport eng (input start, input init, input dir, input addr, input wdata,
               output done, output rdata);
endinterface : rdc_xfer_if
`default_nettype wire
